// >>> core/vir_pkg.sv
// vir_pkg: shared constants and types for the vectored interrupt register block
package vir_pkg;
	localparam int NUM_CH      = 32;
	localparam int NUM_FAST    = 3;
	localparam int PRIO_W      = 4;
	localparam int CHAN_W      = 5;
	localparam int STACK_DEPTH = 16;
	localparam int STACK_CNT_W = 5;
	localparam int HALF_W      = 16;

	// register byte offsets (low address byte only is decoded)
	localparam logic [7:0] OFF_CONTROL  = 8'h00;
	localparam logic [7:0] OFF_CUR_CHAN = 8'h04;
	localparam logic [7:0] OFF_CUR_PRIO = 8'h08;
	localparam logic [7:0] OFF_VECTOR   = 8'h18;
	localparam logic [7:0] OFF_FAST     = 8'h1C;
	localparam logic [7:0] OFF_ENABLE   = 8'h20;
	localparam logic [7:0] OFF_PENDING  = 8'h40;
	localparam logic [7:0] OFF_SRC_LO   = 8'h60;
	localparam logic [7:0] OFF_SRC_HI   = 8'hDC;

	// field positions
	localparam int CTL_IRQ_GATE_BIT = 0;
	localparam int CTL_FIQ_GATE_BIT = 1;
	localparam int FAST_EN_LSB      = 0;
	localparam int FAST_PEND_LSB    = 3;
	localparam int SRC_PRIO_LSB     = 0;
	localparam int SRC_VEC_LSB      = 16;

	// reset values
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [15:0] RST_HALF  = 16'h0000;
	localparam logic [3:0]  RST_PRIO  = 4'h0;
	localparam logic [4:0]  RST_CHAN  = 5'h00;
	localparam logic [2:0]  RST_FAST  = 3'h0;
	localparam logic [1:0]  RST_CTL   = 2'h0;

	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] haddr;
		logic [31:0] hwdata;
		logic        hready;
	} vir_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} vir_ahb_rsp_t;

	typedef struct packed {
		logic [PRIO_W-1:0] prio;
		logic [CHAN_W-1:0] chan;
	} vir_ctx_t;

	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_ACCESS = 1'b1
	} vir_bus_state_t;
endpackage : vir_pkg

// >>> core/vir_src_mem.sv
// vir_src_mem: per-channel vector and priority store with registered word and vector read ports
`timescale 1ns/10ps
module vir_src_mem (
	input  wire logic                          clk_in,
	input  wire logic                          rstn_in,
	input  wire logic                          wr_en_in,
	input  wire logic [vir_pkg::CHAN_W-1:0]    wr_idx_in,
	input  wire logic [31:0]                   wr_data_in,
	input  wire logic [vir_pkg::CHAN_W-1:0]    rd_idx_in,
	output logic      [31:0]                   rd_data_out,
	input  wire logic [vir_pkg::CHAN_W-1:0]    vec_idx_in,
	output logic      [vir_pkg::HALF_W-1:0]    vec_out,
	output logic      [vir_pkg::NUM_CH*vir_pkg::PRIO_W-1:0] prio_out
);
	import vir_pkg::*;

	logic [HALF_W-1:0] vec_mem_reg [NUM_CH];
	logic [PRIO_W-1:0] prio_mem_reg [NUM_CH];

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < NUM_CH; i++) begin
				vec_mem_reg[i]  <= RST_HALF;
				prio_mem_reg[i] <= RST_PRIO;
			end
			rd_data_out <= RST_WORD;
			vec_out     <= RST_HALF;
		end else begin
			if (wr_en_in) begin
				vec_mem_reg[wr_idx_in]  <= wr_data_in[SRC_VEC_LSB +: HALF_W];
				prio_mem_reg[wr_idx_in] <= wr_data_in[SRC_PRIO_LSB +: PRIO_W];
			end
			rd_data_out <= {vec_mem_reg[rd_idx_in], 12'h000, prio_mem_reg[rd_idx_in]};
			vec_out     <= vec_mem_reg[vec_idx_in];
		end
	end

	// priorities feed the arbiter in parallel, so they leave as a flat vector
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			prio_out[i*PRIO_W +: PRIO_W] = prio_mem_reg[i];
		end
	end
endmodule : vir_src_mem

// >>> core/vir_prio_stack.sv
// vir_prio_stack: hardware stack of interrupted priority contexts
`timescale 1ns/10ps
module vir_prio_stack (
	input  wire logic              clk_in,
	input  wire logic              rstn_in,
	input  wire logic              push_in,
	input  wire logic              pop_in,
	input  wire vir_pkg::vir_ctx_t push_ctx_in,
	output vir_pkg::vir_ctx_t      top_ctx_out,
	output logic                   empty_out
);
	import vir_pkg::*;

	vir_ctx_t                  stack_reg [STACK_DEPTH];
	logic [STACK_CNT_W-1:0]    count_reg;
	wire                       full_w   = (count_reg == STACK_CNT_W'(STACK_DEPTH));
	wire                       empty_w  = (count_reg == '0);
	wire  [STACK_CNT_W-1:0]    top_idx_w = count_reg - 5'h01;

	// a push on a full stack is dropped; strictly rising priorities never need more
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_reg[i] <= '0;
			end
			count_reg <= '0;
		end else if (push_in && !full_w) begin
			stack_reg[count_reg[3:0]] <= push_ctx_in;
			count_reg                 <= count_reg + 5'h01;
		end else if (pop_in && !empty_w) begin
			count_reg <= top_idx_w;
		end
	end

	assign top_ctx_out = empty_w ? vir_ctx_t'('0) : stack_reg[top_idx_w[3:0]];
	assign empty_out   = empty_w;
endmodule : vir_prio_stack

// >>> core/vir_regs.sv
// vir_regs: vectored interrupt controller register block behind an AHB-Lite slave
//
// Summary of operation
// R1: hold priority of routine now in service
// R2: vector read acknowledges and drops IRQ request
// R3: acknowledge loads current priority and channel
// R4: ignore requests not above current priority
// R5: vector upper half common, software written
// R6: vector low half is best channel source
// R7: vector word is plain concatenation
// R8: fast channel answered only when enabled
// R9: fast request sets its pending bit
// R10: fast pending cleared by writing one
// R11: one enable bit per channel
// R12: disabled channel never sets pending
// R13: enabled request sets pending until cleared
// R14: channel pending cleared by writing one
// R15: clearing serviced pending bit ends interrupt
// R16: upper half may hold routine base
// R17: upper half may hold jump opcode
// R18: IRQ only for priority above current
// R19: priority write ignored below serviced level
// R20: global gates mask outputs, not logic
// R21: FIQ when fast pending and enabled
`timescale 1ns/10ps
module vir_regs (
	input  wire logic                           clk_in,
	input  wire logic                           rstn_in,
	input  wire vir_pkg::vir_ahb_req_t          ahb_req_in,
	output vir_pkg::vir_ahb_rsp_t               ahb_rsp_out,
	input  wire logic [vir_pkg::NUM_CH-1:0]     irq_src_in,
	input  wire logic [vir_pkg::NUM_FAST-1:0]   fiq_src_in,
	output logic                                irq_request_n_out,
	output logic                                fiq_request_n_out
);
	import vir_pkg::*;

	// best pending channel: {valid, channel, priority}; ties go to the lower channel
	function automatic logic [CHAN_W+PRIO_W:0] pick_best(
		input logic [NUM_CH-1:0]        cand,
		input logic [NUM_CH*PRIO_W-1:0] prios,
		input logic [PRIO_W-1:0]        floor
	);
		logic [PRIO_W-1:0] best_p;
		logic [CHAN_W-1:0] best_c;
		logic              found;
		best_p = floor;
		best_c = '0;
		found  = 1'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (cand[i] && prios[i*PRIO_W +: PRIO_W] > best_p) begin
				best_p = prios[i*PRIO_W +: PRIO_W];
				best_c = CHAN_W'(i);
				found  = 1'h1;
			end
		end
		return {found, best_c, best_p};
	endfunction : pick_best

	function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction : hits

	// reset release through two flops
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_reg <= 1'h0;
			rst_sync_reg <= 1'h0;
		end else begin
			rst_meta_reg <= 1'h1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire rst_n = rst_sync_reg;

	// bus slave state
	vir_bus_state_t state_reg;
	logic           cap_write_reg;
	logic [7:0]     cap_addr_reg;
	logic [31:0]    hrdata_reg;
	logic           hreadyout_reg;

	// block state
	logic [1:0]          ctl_reg;
	logic [HALF_W-1:0]   vec_high_reg;
	logic [NUM_FAST-1:0] fast_enable_reg;
	logic [NUM_FAST-1:0] fast_pending_reg;
	logic [NUM_CH-1:0]   channel_enable_bits_reg;
	logic [NUM_CH-1:0]   channel_pending_bits_reg;
	logic [PRIO_W-1:0]   current_priority_reg;
	logic [CHAN_W-1:0]   current_channel_reg;
	logic                irq_flag_reg;
	logic                irq_request_n_reg;
	logic                fiq_request_n_reg;

	logic [31:0]               src_rd_data_w;
	logic [HALF_W-1:0]         vector_low_half_w;
	logic [NUM_CH*PRIO_W-1:0]  prio_vec_w;
	vir_ctx_t                  stack_top_w;
	logic                      stack_empty_w;

	wire take_w = ahb_req_in.hsel && ahb_req_in.htrans == HTRANS_NONSEQ && ahb_req_in.hready;
	wire acc_w  = (state_reg == ST_ACCESS);
	wire wr_w   = acc_w && cap_write_reg;
	wire rd_w   = acc_w && !cap_write_reg;
	wire [31:0] wdata_w = ahb_req_in.hwdata;

	wire in_src_w  = cap_addr_reg >= OFF_SRC_LO && cap_addr_reg <= OFF_SRC_HI;
	wire src_sel_w = ahb_req_in.haddr[7:0] >= OFF_SRC_LO && ahb_req_in.haddr[7:0] <= OFF_SRC_HI;
	wire [7:0] src_rd_off_w = ahb_req_in.haddr[7:0] - OFF_SRC_LO;
	wire [7:0] src_wr_off_w = cap_addr_reg - OFF_SRC_LO;
	wire [CHAN_W-1:0] src_rd_idx_w = src_sel_w ? src_rd_off_w[6:2] : '0;
	wire [CHAN_W-1:0] src_wr_idx_w = src_wr_off_w[6:2];

	wire wr_ctl_w  = wr_w && hits(cap_addr_reg, OFF_CONTROL);
	wire wr_prio_w = wr_w && hits(cap_addr_reg, OFF_CUR_PRIO);
	wire wr_vec_w  = wr_w && hits(cap_addr_reg, OFF_VECTOR);
	wire wr_fast_w = wr_w && hits(cap_addr_reg, OFF_FAST);
	wire wr_en_w   = wr_w && hits(cap_addr_reg, OFF_ENABLE);
	wire wr_pend_w = wr_w && hits(cap_addr_reg, OFF_PENDING);
	wire wr_src_w  = wr_w && in_src_w;
	wire vec_ack_w = rd_w && hits(cap_addr_reg, OFF_VECTOR);                              // R2

	// arbitration against the running priority
	wire [NUM_CH-1:0] cand_w = channel_pending_bits_reg & channel_enable_bits_reg;
	wire [CHAN_W+PRIO_W:0] best_w = pick_best(cand_w, prio_vec_w, current_priority_reg); // R4 R18
	wire                best_valid_w = best_w[CHAN_W+PRIO_W];
	wire [CHAN_W-1:0]   best_chan_w  = best_w[PRIO_W +: CHAN_W];
	wire [PRIO_W-1:0]   best_prio_w  = best_w[PRIO_W-1:0];

	// end of interrupt: a clear hitting the serviced channel's pending bit
	wire eoi_w = wr_pend_w && !stack_empty_w && wdata_w[current_channel_reg];             // R15
	wire [PRIO_W-1:0] svc_floor_w = stack_empty_w ? RST_PRIO
		: prio_vec_w[current_channel_reg*PRIO_W +: PRIO_W];
	wire prio_wr_ok_w = wr_prio_w && wdata_w[PRIO_W-1:0] >= svc_floor_w;                 // R19

	// pending: hardware set wins over a same-cycle software clear
	wire [NUM_CH-1:0]   pend_set_w  = irq_src_in & channel_enable_bits_reg;               // R12 R13
	wire [NUM_CH-1:0]   pend_clr_w  = wr_pend_w ? wdata_w : '0;                           // R14
	wire [NUM_CH-1:0]   pend_next   = (channel_pending_bits_reg & ~pend_clr_w) | pend_set_w;
	wire [NUM_FAST-1:0] fclr_w      = wr_fast_w ? wdata_w[FAST_PEND_LSB +: NUM_FAST] : '0;
	wire [NUM_FAST-1:0] fast_next   = (fast_pending_reg & ~fclr_w) | fiq_src_in;         // R9 R10
	wire                fiq_active_w = |(fast_pending_reg & fast_enable_reg);             // R8 R21

	// irq flag holds until the vector read; clearing pending alone does not drop it
	wire irq_flag_next = vec_ack_w ? 1'h0 : (irq_flag_reg | best_valid_w);               // R2 R18

	vir_src_mem u_src_mem (
		.clk_in      (clk_in),
		.rstn_in     (rst_n),
		.wr_en_in    (wr_src_w),
		.wr_idx_in   (src_wr_idx_w),
		.wr_data_in  (wdata_w),
		.rd_idx_in   (src_rd_idx_w),
		.rd_data_out (src_rd_data_w),
		.vec_idx_in  (best_chan_w),
		.vec_out     (vector_low_half_w),
		.prio_out    (prio_vec_w)
	);

	vir_prio_stack u_stack (
		.clk_in      (clk_in),
		.rstn_in     (rst_n),
		.push_in     (vec_ack_w && best_valid_w),
		.pop_in      (eoi_w),
		.push_ctx_in ({current_priority_reg, current_channel_reg}),
		.top_ctx_out (stack_top_w),
		.empty_out   (stack_empty_w)
	);

	// read data mux
	logic [31:0] rdata_w;
	always_comb begin
		rdata_w = RST_WORD;
		if (hits(cap_addr_reg, OFF_CONTROL)) begin
			rdata_w = {30'h0000_0000, ctl_reg};
		end else if (hits(cap_addr_reg, OFF_CUR_CHAN)) begin
			rdata_w = {27'h000_0000, current_channel_reg};
		end else if (hits(cap_addr_reg, OFF_CUR_PRIO)) begin
			rdata_w = {28'h000_0000, current_priority_reg};                                 // R1
		end else if (hits(cap_addr_reg, OFF_VECTOR)) begin
			rdata_w = {vec_high_reg, vector_low_half_w};                                   // R5 R6 R7
		end else if (hits(cap_addr_reg, OFF_FAST)) begin
			rdata_w = {26'h000_0000, fast_pending_reg, fast_enable_reg};
		end else if (hits(cap_addr_reg, OFF_ENABLE)) begin
			rdata_w = channel_enable_bits_reg;
		end else if (hits(cap_addr_reg, OFF_PENDING)) begin
			rdata_w = channel_pending_bits_reg;
		end else if (in_src_w) begin
			rdata_w = src_rd_data_w;
		end
	end

	// one wait state per transfer so hrdata and hreadyout leave a flop; hresp is tied to OKAY
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= ST_IDLE;
			cap_write_reg <= 1'h0;
			cap_addr_reg  <= 8'h00;
			hrdata_reg    <= RST_WORD;
			hreadyout_reg <= 1'h1;
		end else if (acc_w) begin
			state_reg     <= ST_IDLE;
			hreadyout_reg <= 1'h1;
			hrdata_reg    <= cap_write_reg ? RST_WORD : rdata_w;
		end else if (take_w) begin
			state_reg     <= ST_ACCESS;
			hreadyout_reg <= 1'h0;
			cap_write_reg <= ahb_req_in.hwrite;
			cap_addr_reg  <= ahb_req_in.haddr[7:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reg                  <= RST_CTL;
			vec_high_reg             <= RST_HALF;
			fast_enable_reg          <= RST_FAST;
			fast_pending_reg         <= RST_FAST;
			channel_enable_bits_reg  <= RST_WORD;
			channel_pending_bits_reg <= RST_WORD;
		end else begin
			if (wr_ctl_w) begin
				ctl_reg <= wdata_w[1:0];
			end
			if (wr_vec_w) begin
				vec_high_reg <= wdata_w[SRC_VEC_LSB +: HALF_W];                              // R5
			end
			if (wr_fast_w) begin
				fast_enable_reg <= wdata_w[FAST_EN_LSB +: NUM_FAST];                        // R8
			end
			if (wr_en_w) begin
				channel_enable_bits_reg <= wdata_w;                                         // R11
			end
			fast_pending_reg         <= fast_next;                                          // R10
			channel_pending_bits_reg <= pend_next;                                          // R13 R14
		end
	end

	// acknowledge first, then end of interrupt, then software promotion
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			current_priority_reg <= RST_PRIO;
			current_channel_reg  <= RST_CHAN;
		end else if (vec_ack_w && best_valid_w) begin
			current_priority_reg <= best_prio_w;                                            // R3
			current_channel_reg  <= best_chan_w;                                            // R3
		end else if (eoi_w) begin
			current_priority_reg <= stack_top_w.prio;                                       // R15
			current_channel_reg  <= stack_top_w.chan;                                       // R15
		end else if (prio_wr_ok_w) begin
			current_priority_reg <= wdata_w[PRIO_W-1:0];                                    // R19
		end
	end

	// gates act only here, the arbitration above keeps running
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_reg      <= 1'h0;
			irq_request_n_reg <= 1'h1;
			fiq_request_n_reg <= 1'h1;
		end else begin
			irq_flag_reg      <= irq_flag_next;
			irq_request_n_reg <= !(irq_flag_reg && ctl_reg[CTL_IRQ_GATE_BIT]);           // R20
			fiq_request_n_reg <= !(fiq_active_w && ctl_reg[CTL_FIQ_GATE_BIT]);           // R20 R21
		end
	end

	// request lines leave active-low flops directly, no gate after the register
	assign irq_request_n_out     = irq_request_n_reg;
	assign fiq_request_n_out     = fiq_request_n_reg;
	assign ahb_rsp_out.hrdata    = hrdata_reg;
	assign ahb_rsp_out.hreadyout = hreadyout_reg;
	assign ahb_rsp_out.hresp     = HRESP_OKAY;

	chk_ack_drops_irq: assert property (@(posedge clk_in) disable iff (!rst_n) // R2
		vec_ack_w |-> ##2 irq_request_n_out)
		else $error("irq request still low two cycles after vector read");

	chk_ack_loads_ctx: assert property (@(posedge clk_in) disable iff (!rst_n) // R3
		(vec_ack_w && best_valid_w) |=> (current_priority_reg == $past(best_prio_w)
			&& current_channel_reg == $past(best_chan_w)))
		else $error("acknowledge did not load priority and channel");

	chk_pend_masked: assert property (@(posedge clk_in) disable iff (!rst_n) // R12
		(pend_next & ~channel_pending_bits_reg & ~channel_enable_bits_reg) == '0)
		else $error("pending set on a disabled channel");

	chk_pend_set_wins: assert property (@(posedge clk_in) disable iff (!rst_n) // R13
		(pend_set_w != '0) |=> ((channel_pending_bits_reg & $past(pend_set_w)) == $past(pend_set_w)))
		else $error("enabled request did not set its pending bit");

	chk_pend_w1c: assert property (@(posedge clk_in) disable iff (!rst_n) // R14
		(wr_pend_w && (pend_clr_w & ~pend_set_w) != '0)
		|=> ((channel_pending_bits_reg & $past(pend_clr_w) & ~$past(pend_set_w)) == '0))
		else $error("writing one did not clear a pending bit");

	chk_fast_w1c: assert property (@(posedge clk_in) disable iff (!rst_n) // R10
		(wr_fast_w && fiq_src_in == '0) |=> ((fast_pending_reg & $past(fclr_w)) == '0))
		else $error("fast pending bit not cleared by writing one");

	chk_fiq_output: assert property (@(posedge clk_in) disable iff (!rst_n) // R21
		(fiq_active_w && ctl_reg[CTL_FIQ_GATE_BIT]) |=> !fiq_request_n_out)
		else $error("fiq not raised for an enabled pending fast channel");

	chk_prio_floor: assert property (@(posedge clk_in) disable iff (!rst_n) // R19
		(wr_prio_w && !prio_wr_ok_w && !vec_ack_w && !eoi_w) |=> $stable(current_priority_reg))
		else $error("priority write below serviced level was accepted");

	chk_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n) // R20
		!ctl_reg[CTL_IRQ_GATE_BIT] |=> irq_request_n_out)
		else $error("irq output active while globally gated");

	chk_eoi_pops: assert property (@(posedge clk_in) disable iff (!rst_n) // R15
		(eoi_w && !vec_ack_w) |=> current_priority_reg == $past(stack_top_w.prio))
		else $error("end of interrupt did not restore previous priority");

	chk_fast_set: assert property (@(posedge clk_in) disable iff (!rst_n) // R9
		(fiq_src_in != '0) |=> ((fast_pending_reg & $past(fiq_src_in)) == $past(fiq_src_in)))
		else $error("fast request did not set its pending bit");

	chk_fast_enable_gate: assert property (@(posedge clk_in) disable iff (!rst_n) // R8
		((fast_pending_reg & fast_enable_reg) == '0) |=> fiq_request_n_out)
		else $error("fiq raised for a disabled fast channel");

	chk_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n) // R11
		wr_en_w |=> (channel_enable_bits_reg == $past(wdata_w)))
		else $error("channel enable write not taken");

	chk_irq_needs_cand: assert property (@(posedge clk_in) disable iff (!rst_n) // R18
		(!irq_flag_reg && !best_valid_w) |=> !irq_flag_reg)
		else $error("irq flag set with no candidate above current priority");

	chk_vec_concat: assert property (@(posedge clk_in) disable iff (!rst_n) // R5 R6 R7
		vec_ack_w |=> (ahb_rsp_out.hrdata == {$past(vec_high_reg), $past(vector_low_half_w)}))
		else $error("vector word is not upper half joined to source vector");

	chk_chan_read_only: assert property (@(posedge clk_in) disable iff (!rst_n) // R3
		(wr_w && hits(cap_addr_reg, OFF_CUR_CHAN)) |=> $stable(current_channel_reg))
		else $error("current channel changed by a bus write");
endmodule : vir_regs

// >>> verification/vir_cpu_model.sv
// vir_cpu_model: processor core model, AHB-Lite master that fetches vectors
`timescale 1ns/10ps
module vir_cpu_model (
	input  wire logic                  clk_in,
	input  wire vir_pkg::vir_ahb_rsp_t rsp_in,
	input  wire logic                  irq_request_n_in,
	output vir_pkg::vir_ahb_req_t      req_out
);
	import vir_pkg::*;
	logic        hsel_reg   = 1'h0;
	logic [1:0]  htrans_reg = 2'h0;
	logic        hwrite_reg = 1'h0;
	logic [31:0] haddr_reg  = 32'h0;
	logic [31:0] hwdata_reg = 32'h0;
	// single slave: its hreadyout is the bus hready
	assign req_out = '{hsel_reg, htrans_reg, hwrite_reg, 3'h2, haddr_reg, hwdata_reg, rsp_in.hreadyout};

	// entered just after a rising edge; holds each phase until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel_reg   <= 1'h1;
		htrans_reg <= HTRANS_NONSEQ;
		hwrite_reg <= w;
		haddr_reg  <= {24'h0, a};
		do @(posedge clk_in); while (rsp_in.hreadyout !== 1'h1);
		htrans_reg <= 2'h0;
		hwdata_reg <= d;
		do @(posedge clk_in); while (rsp_in.hreadyout !== 1'h1);
		q = rsp_in.hrdata;
		// released data lines do not keep the last value
		hwdata_reg <= ~d;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'h1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'h0, a, 32'h0, q);
	endtask : rd

	task automatic program_src(input int ch, input logic [3:0] p, input logic [15:0] v);
		wr(OFF_SRC_LO + 8'(4 * ch), {v, 12'h000, p});
	endtask : program_src

	// waits a bounded time for the request line, then acknowledges by reading the vector
	task automatic service(output logic [31:0] vec);
		int n;
		n = 0;
		while (irq_request_n_in !== 1'h0 && n < 20) begin
			@(posedge clk_in);
			n++;
		end
		rd(OFF_VECTOR, vec);
	endtask : service

	task automatic eoi(input int ch);
		wr(OFF_PENDING, 32'h1 << ch);
	endtask : eoi
endmodule : vir_cpu_model

// >>> verification/vir_regs_test.sv
// vir_regs_test: self-checking bench for the vectored interrupt register block
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; $display("Error %0t: got %h expected %h", $time, got, exp); end end
module vir_regs_test;
	import vir_pkg::*;
	logic                clk_in  = 1'h0;
	logic                rstn_in = 1'h0;
	logic [NUM_CH-1:0]   irq_src = 32'h0;
	logic [NUM_FAST-1:0] fiq_src = 3'h0;
	vir_ahb_req_t        req;
	vir_ahb_rsp_t        rsp;
	logic                irq_n;
	logic                fiq_n;
	logic [31:0]         q;
	int                  n_errors    = 0;
	int                  comparisons = 0;
	int                  cycles      = 0;
	localparam logic [7:0] OFFS [8] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1C, 8'h20, 8'h40, 8'h60};

	always #5 clk_in = ~clk_in;

	vir_regs DUT (.clk_in(clk_in), .rstn_in(rstn_in), .ahb_req_in(req), .ahb_rsp_out(rsp), .irq_src_in(irq_src),
		.fiq_src_in(fiq_src), .irq_request_n_out(irq_n), .fiq_request_n_out(fiq_n));
	vir_cpu_model u_cpu (.clk_in(clk_in), .rsp_in(rsp), .irq_request_n_in(irq_n), .req_out(req));

	function automatic logic req_line(input logic f);
		return f ? fiq_n : irq_n;
	endfunction : req_line

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		u_cpu.rd(a, q);
		`CHK(q, e)
		`CHK(rsp.hresp, HRESP_OKAY)
	endtask : rd_chk

	task automatic pulse(input logic [NUM_CH-1:0] s, input logic [NUM_FAST-1:0] f);
		irq_src <= s;
		fiq_src <= f;
		@(posedge clk_in);
		irq_src <= 32'h0;
		fiq_src <= 3'h0;
		@(posedge clk_in);
	endtask : pulse

	task automatic expect_within(input logic f, input logic lvl, input int n);
		for (int k = 0; k < n && req_line(f) !== lvl; k++) begin
			@(posedge clk_in);
		end
		`CHK(req_line(f), lvl)
	endtask : expect_within

	task automatic expect_hold(input logic f, input logic lvl, input int n);
		repeat (n) begin
			@(posedge clk_in);
			`CHK(req_line(f), lvl)
		end
	endtask : expect_hold

	task automatic t_reset_map;
		for (int i = 0; i < 8; i++) rd_chk(OFFS[i], 32'h0);
		u_cpu.wr(8'h10, 32'hFFFF_FFFF);
		rd_chk(8'h10, 32'h0);
		u_cpu.wr(OFF_CUR_CHAN, 32'h1F);
		rd_chk(OFF_CUR_CHAN, 32'h0);
		u_cpu.wr(OFF_ENABLE, 32'h0000_0224);
		rd_chk(OFF_ENABLE, 32'h0000_0224);
		u_cpu.program_src(5, 4'h3, 16'hA505);
		u_cpu.program_src(9, 4'h6, 16'h9009);
		u_cpu.program_src(2, 4'h0, 16'h2222);
		u_cpu.wr(OFF_VECTOR, 32'hBEEF_1234);
		u_cpu.rd(OFF_VECTOR, q);
		`CHK(q[31:16], 16'hBEEF)
	endtask : t_reset_map

	task automatic t_mask;
		pulse(32'h0000_0084, 3'h0);
		rd_chk(OFF_PENDING, 32'h4);
		u_cpu.wr(OFF_CONTROL, 32'h1);
		expect_hold(1'h0, 1'h1, 6);
		u_cpu.wr(OFF_PENDING, 32'h0);
		rd_chk(OFF_PENDING, 32'h4);
		u_cpu.wr(OFF_PENDING, 32'h4);
		rd_chk(OFF_PENDING, 32'h0);
	endtask : t_mask

	task automatic t_nested;
		u_cpu.wr(OFF_CONTROL, 32'h0);
		pulse(32'h0000_0220, 3'h0);
		expect_hold(1'h0, 1'h1, 6);
		rd_chk(OFF_PENDING, 32'h220);
		u_cpu.wr(OFF_CONTROL, 32'h1);
		expect_within(1'h0, 1'h0, 6);
		u_cpu.service(q);
		`CHK(q, 32'hBEEF_9009)
		expect_within(1'h0, 1'h1, 3);
		rd_chk(OFF_CUR_PRIO, 32'h6);
		rd_chk(OFF_CUR_CHAN, 32'h9);
		rd_chk(OFF_PENDING, 32'h220);
		expect_hold(1'h0, 1'h1, 6);
		u_cpu.wr(OFF_CUR_PRIO, 32'h4);
		rd_chk(OFF_CUR_PRIO, 32'h6);
		u_cpu.wr(OFF_CUR_PRIO, 32'h7);
		rd_chk(OFF_CUR_PRIO, 32'h7);
		u_cpu.eoi(9);
		rd_chk(OFF_CUR_PRIO, 32'h0);
		expect_within(1'h0, 1'h0, 6);
		u_cpu.service(q);
		`CHK(q, 32'hBEEF_A505)
		rd_chk(OFF_CUR_CHAN, 32'h5);
		expect_within(1'h0, 1'h1, 3);
		pulse(32'h0000_0020, 3'h0);
		expect_hold(1'h0, 1'h1, 6);
		u_cpu.eoi(5);
		rd_chk(OFF_CUR_PRIO, 32'h0);
		rd_chk(OFF_PENDING, 32'h0);
	endtask : t_nested

	task automatic t_fast;
		u_cpu.wr(OFF_CONTROL, 32'h2);
		pulse(32'h0, 3'h1);
		rd_chk(OFF_FAST, 32'h8);
		expect_hold(1'h1, 1'h1, 4);
		u_cpu.wr(OFF_FAST, 32'h1);
		expect_within(1'h1, 1'h0, 4);
		u_cpu.wr(OFF_CONTROL, 32'h0);
		expect_within(1'h1, 1'h1, 4);
		rd_chk(OFF_FAST, 32'h9);
		u_cpu.wr(OFF_CONTROL, 32'h2);
		expect_within(1'h1, 1'h0, 4);
		u_cpu.wr(OFF_FAST, 32'h9);
		rd_chk(OFF_FAST, 32'h1);
		expect_hold(1'h1, 1'h1, 4);
		for (int c = 1; c < 3; c++) begin
			pulse(32'h0, 3'h1 << c);
			rd_chk(OFF_FAST, 32'h1 | (32'h8 << c));
			expect_hold(1'h1, 1'h1, 3);
			u_cpu.wr(OFF_FAST, 32'h1 | (32'h8 << c));
			rd_chk(OFF_FAST, 32'h1);
		end
	endtask : t_fast

	task automatic test_done;
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// ceiling well above the few hundred cycles the scenarios need
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			$display("Error %0t: timeout", $time);
			test_done;
		end
	end

	initial begin
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		t_reset_map;
		t_mask;
		t_nested;
		t_fast;
		test_done;
	end
endmodule : vir_regs_test
